// >>> field_pins_model.sv
// field input model: encoder phases, pulse clocks, reset and start lines
`timescale 1ns/10ps
`default_nettype none

module field_pins_model (
   input  wire logic clk,
   output logic      pin_a,
   output logic      pin_b,
   output logic      pin_reset,
   output logic      pin_start
);
   int idx = 0;

   // a and b serve several jobs by mode (clock/up/A, direction/down/B); all rest low at start
   initial begin
      pin_a = 1'h0;
      pin_b = 1'h0;
      pin_reset = 1'h0;
      pin_start = 1'h0;
   end

   // move just after a rising edge, like the bench
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // pulses of the 160 ns link period on a, b or both together
   task automatic pulses(input logic on_a, input logic on_b, input int n);
      repeat (n) begin
         pin_a = on_a;
         pin_b = on_b;
         wait_clk(8);
         pin_a = 1'h0;
         pin_b = 1'h0;
         wait_clk(8);
      end
   endtask

   // quarter steps of 40 ns; a leads b when counting up
   task automatic quad(input int n, input logic up);
      repeat (n) begin
         idx = up ? (idx + 1) % 4 : (idx + 3) % 4;
         pin_a = idx == 1 || idx == 2;
         pin_b = idx >= 2;
         wait_clk(4);
      end
   endtask

   // static levels for direction, reset and start
   task automatic set_lines(input logic b, input logic rst, input logic st);
      pin_b = b;
      pin_reset = rst;
      pin_start = st;
      wait_clk(10);
   endtask
endmodule // field_pins_model

`default_nettype wire

// >>> high_speed_event_counter.sv
// high-speed event counter: twelve modes, staged updates, event pulses
//
// Function
// - modes 0-2 single clock, internal direction
// - modes 3-5 single clock, external direction
// - modes 6-8 separate up and down clocks
// - modes 9-11 decode quadrature phases A, B
// - near-coincident up/down edges leave count alone
// - config bit 0 sets reset polarity
// - config bit 1 sets start polarity
// - config bit 2 selects 4x or 1x
// - defaults: high reset, high start, 4x
// - config bits sampled only at definition
// - definition fixed until controller stops
// - control bit 3 holds direction value
// - control bit 4 applies new direction
// - control bit 5 loads staged preset
// - control bit 6 loads staged count
// - control bit 7 enables or disables counter
// - control inputs examined only at update
// - count and preset are signed 32-bit
// - count readable always, written by update
// - active reset clears and holds count
// - inactive start freezes count, ignores clocks
// - reset ignored without start; start clears
// - events: equal preset, reset, direction change
`timescale 1ns/10ps
`default_nettype none

module high_speed_event_counter #(
   parameter int unsigned COUNT_W      = hsc_pkg::COUNT_W,
   parameter int unsigned COINC_CYCLES = hsc_pkg::COINC_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               srst,
   // field pins: clock/up/A, direction/down/B, reset, start
   input  wire logic               pin_a,
   input  wire logic               pin_b,
   input  wire logic               pin_reset,
   input  wire logic               pin_start,
   // controlling program side
   input  wire logic               controller_stopped,
   input  wire logic               counter_definition_command,
   input  wire logic [3:0]         definition_mode,
   input  wire logic               counter_update_command,
   input  wire logic [7:0]         counter_control_byte,
   input  wire logic [COUNT_W-1:0] staged_current_value,
   input  wire logic [COUNT_W-1:0] staged_preset_value,
   output logic      [COUNT_W-1:0] count_read_path,
   output logic                    counter_defined,
   output logic                    counter_enabled,
   output logic                    count_direction_up,
   output logic                    count_equals_preset,
   output logic                    equal_event,
   output logic                    reset_event,
   output logic                    direction_event
);

   generate
      if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_count_w
         $error("COUNT_W must lie between 2 and 32");
      end
      if (COINC_CYCLES < 1 || COINC_CYCLES >= (1 << hsc_pkg::COINC_W)) begin : g_bad_coinc
         $error("COINC_CYCLES must fit the window timer");
      end
   endgenerate

   localparam logic [hsc_pkg::COINC_W-1:0] COINC_LAST =
      hsc_pkg::COINC_W'(COINC_CYCLES - 1);

   // synchronised pins and their edges
   logic [3:0] pin_level;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;

   pin_sync_edge #(
      .WIDTH (4)
   ) u_pin_sync (
      .clk    (clk),
      .srst   (srst),
      .pin_in ({pin_start, pin_reset, pin_b, pin_a}),
      .level  (pin_level),
      .rise   (pin_rise),
      .fall   (pin_fall)
   );

   // configuration state, fixed between definition and stop
   logic       defined_reg,   defined_next;
   logic [3:0] mode_reg,      mode_next;
   logic       rst_pol_reg,   rst_pol_next;
   logic       start_pol_reg, start_pol_next;
   logic       rate_1x_reg,   rate_1x_next;

   // counting state
   logic                  enable_reg,   enable_next;
   logic                  dir_reg,      dir_next;
   logic [COUNT_W-1:0]    count_reg,    count_next;
   logic [COUNT_W-1:0]    preset_reg,   preset_next;
   logic                  rst_held_reg, rst_held_next;
   logic                  eq_reg,       eq_next;
   logic                  eq_evt_reg,   eq_evt_next;
   logic                  rst_evt_reg,  rst_evt_next;
   logic                  dir_evt_reg,  dir_evt_next;

   // two-clock coincidence filter state
   hsc_pkg::coinc_t              co_reg,    co_next;
   logic [hsc_pkg::COINC_W-1:0]  timer_reg, timer_next;

   // decoded count requests and gating terms
   hsc_pkg::family_t fam;
   logic             step_up;
   logic             step_down;
   logic             two_up;
   logic             two_down;
   logic             rst_active;
   logic             start_active;
   logic             rst_effective;
   logic             running;
   logic             b_before;

   // definition: sample mode and polarity bits once, release on stop
   always_comb begin
      defined_next   = defined_reg;
      mode_next      = mode_reg;
      rst_pol_next   = rst_pol_reg;
      start_pol_next = start_pol_reg;
      rate_1x_next   = rate_1x_reg;
      if (controller_stopped) begin
         defined_next = 1'b0;
      end else if (counter_definition_command && !defined_reg &&
                   definition_mode <= hsc_pkg::MODE_LAST) begin
         defined_next   = 1'b1;
         mode_next      = definition_mode;
         rst_pol_next   = counter_control_byte[hsc_pkg::CTRL_RST_POL_BIT];
         start_pol_next = counter_control_byte[hsc_pkg::CTRL_START_POL_BIT];
         rate_1x_next   = counter_control_byte[hsc_pkg::CTRL_RATE_BIT];
      end
   end

   // reset values give high reset, high start and 4x until defined
   always_ff @(posedge clk) begin
      if (srst) begin
         defined_reg   <= 1'b0;
         mode_reg      <= hsc_pkg::MODE_RESET;
         rst_pol_reg   <= hsc_pkg::RST_POL_RESET;
         start_pol_reg <= hsc_pkg::START_POL_RESET;
         rate_1x_reg   <= hsc_pkg::RATE_1X_RESET;
      end else begin
         defined_reg   <= defined_next;
         mode_reg      <= mode_next;
         rst_pol_reg   <= rst_pol_next;
         start_pol_reg <= start_pol_next;
         rate_1x_reg   <= rate_1x_next;
      end
   end

   // reset and start levels after polarity, gated by the mode's pin set
   always_comb begin
      fam          = hsc_pkg::mode_family(mode_reg);
      rst_active   = hsc_pkg::mode_has_reset(mode_reg) &&
                     (pin_level[2] ^ rst_pol_reg);
      start_active = !hsc_pkg::mode_has_start(mode_reg) ||
                     (pin_level[3] ^ start_pol_reg);
      // reset only bites while start lets the counter run
      rst_effective = defined_reg && enable_reg &&
                      rst_active && start_active;
      running = defined_reg && enable_reg && start_active &&
                !rst_effective;
   end

   // per-family decode of a single count step
   always_comb begin
      step_up   = 1'b0;
      step_down = 1'b0;
      // phase B level one cycle earlier, rebuilt from its edges
      b_before  = pin_level[1] ^ (pin_rise[1] | pin_fall[1]);
      case (fam)
         hsc_pkg::FAM_INT_DIR: begin
            step_up   = pin_rise[0] && dir_reg;
            step_down = pin_rise[0] && !dir_reg;
         end
         hsc_pkg::FAM_EXT_DIR: begin
            step_up   = pin_rise[0] && pin_level[1];
            step_down = pin_rise[0] && !pin_level[1];
         end
         hsc_pkg::FAM_TWO_CLK: begin
            step_up   = two_up;
            step_down = two_down;
         end
         default: begin
            if (rate_1x_reg) begin
               // one count per cycle, on the rising edge of A
               step_up   = pin_rise[0] && !pin_level[1];
               step_down = pin_rise[0] && pin_level[1];
            end else if ((pin_rise[0] | pin_fall[0]) ^
                         (pin_rise[1] | pin_fall[1])) begin
               // every edge of either phase; a double jump is ignored
               step_up   = pin_level[0] ^ b_before;
               step_down = !(pin_level[0] ^ b_before);
            end
         end
      endcase
   end

   // two-clock filter: an edge waits out the window for its opposite;
   // this delays a two-clock step by the window length, or until the next edge of the same clock
   always_comb begin
      co_next    = co_reg;
      timer_next = timer_reg;
      two_up     = 1'b0;
      two_down   = 1'b0;
      if (fam != hsc_pkg::FAM_TWO_CLK || !running) begin
         co_next    = hsc_pkg::CO_IDLE;
         timer_next = '0;
      end else begin
         case (co_reg)
            hsc_pkg::CO_IDLE: begin
               timer_next = '0;
               if (pin_rise[0] && !pin_rise[1]) begin
                  co_next = hsc_pkg::CO_UP;
               end else if (pin_rise[1] && !pin_rise[0]) begin
                  co_next = hsc_pkg::CO_DOWN;
               end
            end
            hsc_pkg::CO_UP: begin
               if (pin_rise[1]) begin
                  co_next = hsc_pkg::CO_IDLE;
               end else if (pin_rise[0]) begin
                  two_up     = 1'b1;
                  timer_next = '0;
               end else if (timer_reg == COINC_LAST) begin
                  two_up  = 1'b1;
                  co_next = hsc_pkg::CO_IDLE;
               end else begin
                  timer_next = timer_reg + 1'b1;
               end
            end
            hsc_pkg::CO_DOWN: begin
               if (pin_rise[0]) begin
                  co_next = hsc_pkg::CO_IDLE;
               end else if (pin_rise[1]) begin
                  two_down   = 1'b1;
                  timer_next = '0;
               end else if (timer_reg == COINC_LAST) begin
                  two_down = 1'b1;
                  co_next  = hsc_pkg::CO_IDLE;
               end else begin
                  timer_next = timer_reg + 1'b1;
               end
            end
            default: begin
               co_next = hsc_pkg::CO_IDLE;
            end
         endcase
      end
   end

   // count, preset, direction and events; update wins over a step,
   // and an effective reset wins over both
   always_comb begin
      enable_next   = enable_reg;
      dir_next      = dir_reg;
      count_next    = count_reg;
      preset_next   = preset_reg;
      rst_held_next = rst_effective;
      dir_evt_next  = 1'b0;
      if (controller_stopped) begin
         enable_next = 1'b0;
      end
      if (running && step_up) begin
         count_next = count_reg + 1'b1;
         dir_next   = 1'b1;
      end else if (running && step_down) begin
         count_next = count_reg - 1'b1;
         dir_next   = 1'b0;
      end
      // staged values are looked at only on the update command
      if (counter_update_command && defined_reg && !controller_stopped) begin
         if (counter_control_byte[hsc_pkg::CTRL_DIR_WR_BIT]) begin
            dir_next = counter_control_byte[hsc_pkg::CTRL_DIR_BIT];
         end
         if (counter_control_byte[hsc_pkg::CTRL_PRESET_WR_BIT]) begin
            preset_next = staged_preset_value;
         end
         if (counter_control_byte[hsc_pkg::CTRL_COUNT_WR_BIT]) begin
            count_next = staged_current_value;
         end
         enable_next = counter_control_byte[hsc_pkg::CTRL_ENABLE_BIT];
      end
      if (rst_effective) begin
         count_next = '0;
      end
      // direction changes only count from hardware, in modes 3 to 11
      if (fam != hsc_pkg::FAM_INT_DIR && running && (step_up || step_down) &&
          dir_next != dir_reg) begin
         dir_evt_next = 1'b1;
      end
      eq_next      = count_next == preset_next;
      // event when count arrives at the preset, not while it rests there
      eq_evt_next  = defined_reg && enable_reg && eq_next &&
                     count_next != count_reg;
      rst_evt_next = rst_effective && !rst_held_reg;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         enable_reg   <= 1'b0;
         dir_reg      <= hsc_pkg::DIR_RESET;
         count_reg    <= hsc_pkg::COUNT_RESET[COUNT_W-1:0];
         preset_reg   <= hsc_pkg::PRESET_RESET[COUNT_W-1:0];
         rst_held_reg <= 1'b0;
         eq_reg       <= 1'b0;
         eq_evt_reg   <= 1'b0;
         rst_evt_reg  <= 1'b0;
         dir_evt_reg  <= 1'b0;
         co_reg       <= hsc_pkg::CO_IDLE;
         timer_reg    <= '0;
      end else begin
         enable_reg   <= enable_next;
         dir_reg      <= dir_next;
         count_reg    <= count_next;
         preset_reg   <= preset_next;
         rst_held_reg <= rst_held_next;
         eq_reg       <= eq_next;
         eq_evt_reg   <= eq_evt_next;
         rst_evt_reg  <= rst_evt_next;
         dir_evt_reg  <= dir_evt_next;
         co_reg       <= co_next;
         timer_reg    <= timer_next;
      end
   end

   // every output straight from a flip-flop
   assign count_read_path     = count_reg;
   assign counter_defined     = defined_reg;
   assign counter_enabled     = enable_reg;
   assign count_direction_up  = dir_reg;
   assign count_equals_preset = eq_reg;
   assign equal_event         = eq_evt_reg;
   assign reset_event         = rst_evt_reg;
   assign direction_event     = dir_evt_reg;

endmodule // high_speed_event_counter

`default_nettype wire

// >>> high_speed_event_counter_tb.sv
// self-checking bench for the high-speed event counter
`timescale 1ns/10ps
`default_nettype none

module high_speed_event_counter_tb;
   localparam int unsigned COUNT_W      = 32;
   localparam int unsigned COINC_CYCLES = 2;
   logic        clk, srst, pin_a, pin_b, pin_reset, pin_start;
   logic        controller_stopped = 1'h0;
   logic        counter_definition_command = 1'h0;
   logic        counter_update_command = 1'h0;
   logic [3:0]  definition_mode = 4'h0;
   logic [7:0]  counter_control_byte = 8'h00;
   logic [31:0] staged_current_value = 32'h0, staged_preset_value = 32'h0;
   logic [31:0] count_read_path;
   logic        counter_defined, counter_enabled, count_direction_up;
   logic        count_equals_preset, equal_event, reset_event, direction_event;
   int          mismatches = 0, compares = 0, seed = 18677, exp_cnt = 0;
   int          n_eq = 0, n_rst = 0, n_dir = 0, v, r;

   high_speed_event_counter #(.COUNT_W(COUNT_W),
      .COINC_CYCLES(COINC_CYCLES)) DUT (.*);
   field_pins_model FP (.*);

   // 100 MHz clock
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // tally event pulses mid-cycle, where they are settled
   always @(negedge clk) begin
      if (equal_event === 1'h1) n_eq++;
      if (reset_event === 1'h1) n_rst++;
      if (direction_event === 1'h1) n_dir++;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t: value %h not %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t: flag %b not %b", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // a stopped cycle first, since a defined counter refuses redefinition
   task automatic define(input logic [3:0] m, input logic [7:0] cfg);
      controller_stopped = 1'h1;
      tick(1);
      controller_stopped = 1'h0;
      counter_definition_command = 1'h1;
      definition_mode = m;
      counter_control_byte = cfg;
      tick(1);
      counter_definition_command = 1'h0;
      tick(1);
   endtask

   // stage values and byte, then pulse the update; model follows bit 6
   task automatic update(input logic [7:0] b, input int cur, input int pre);
      counter_control_byte = b;
      staged_current_value = 32'(cur);
      staged_preset_value = 32'(pre);
      counter_update_command = 1'h1;
      tick(1);
      counter_update_command = 1'h0;
      if (b[6]) exp_cnt = cur;
      tick(2);
   endtask

   // a hang is cut short here
   initial begin
      #300000;
      mismatches++;
      report_and_stop();
   end

   initial begin
      srst = 1'h1;
      tick(6);
      srst = 1'h0;
      tick(3);
      chk_val(count_read_path, 32'h0000_0000);
      chk_flag(count_direction_up, 1'h1);
      // update before any definition is ignored
      update(8'hF8, $random(seed), 0);
      exp_cnt = 0;
      chk_flag(counter_enabled, 1'h0);
      chk_val(count_read_path, 32'(exp_cnt));
      // mode 0 with default config counts up into the preset
      define(4'h0, 8'h00);
      v = $random(seed);
      update(8'hF8, v, v + 3);
      n_eq = 0;
      chk_val(count_read_path, 32'(exp_cnt));
      chk_flag(counter_enabled, 1'h1);
      FP.pulses(1'h1, 1'h0, 3);
      exp_cnt += 3;
      tick(10);
      chk_val(count_read_path, 32'(exp_cnt));
      chk_val(32'(n_eq), 32'h0000_0001);
      update(8'h90, 0, 0);
      FP.pulses(1'h1, 1'h0, 2);
      exp_cnt -= 2;
      tick(10);
      chk_val(count_read_path, 32'(exp_cnt));
      chk_flag(count_direction_up, 1'h0);
      // staged values without the command change nothing
      staged_current_value = $random(seed);
      counter_control_byte = 8'hE0;
      tick(3);
      chk_val(count_read_path, 32'(exp_cnt));
      update(8'hA0, 0, exp_cnt);
      chk_flag(count_equals_preset, 1'h1);
      // disabled counter ignores clocks but still takes a load
      update(8'h40, v, -1);
      FP.pulses(1'h1, 1'h0, 2);
      tick(10);
      chk_val(count_read_path, 32'(exp_cnt));
      // a second definition without a stop must leave mode 0 in place
      counter_definition_command = 1'h1;
      definition_mode = 4'h9;
      tick(1);
      counter_definition_command = 1'h0;
      update(8'hF8, 0, -1);
      FP.pulses(1'h1, 1'h0, 2);
      tick(10);
      chk_val(count_read_path, 32'h0000_0002);
      // quadrature at 4x then 1x; the rate bit at update must not matter
      for (r = 0; r < 2; r++) begin
         define(4'h9, 8'(r << 2));
         update(8'hFC ^ 8'(r << 2), 0, -1);
         n_dir = 0;
         FP.quad(8, 1'h1);
         tick(10);
         chk_val(count_read_path, (r == 1) ? 32'h2 : 32'h8);
         FP.quad(8, 1'h0);
         tick(10);
         chk_val(count_read_path, 32'h0000_0000);
         chk_val(32'(n_dir), 32'h0000_0001);
      end
      // external direction low counts down; low reset clears and holds
      FP.set_lines(1'h0, 1'h1, 1'h0);
      define(4'h4, 8'h01);
      update(8'hF8, 5, -1);
      n_rst = 0;
      FP.pulses(1'h1, 1'h0, 3);
      tick(10);
      chk_val(count_read_path, 32'h0000_0002);
      FP.set_lines(1'h0, 1'h0, 1'h0);
      FP.pulses(1'h1, 1'h0, 2);
      tick(10);
      chk_val(count_read_path, 32'h0000_0000);
      chk_val(32'(n_rst), 32'h0000_0001);
      // two clocks: lone edges count, coincident edges cancel
      define(4'h7, 8'h00);
      update(8'hF8, 0, -1);
      FP.pulses(1'h1, 1'h0, 3);
      FP.pulses(1'h0, 1'h1, 1);
      tick(10);
      chk_val(count_read_path, 32'h0000_0002);
      n_dir = 0;
      FP.pulses(1'h1, 1'h1, 1);
      tick(10);
      chk_val(count_read_path, 32'h0000_0002);
      chk_val(32'(n_dir), 32'h0000_0000);
      // start active low: frozen while off, reset waits for start
      FP.set_lines(1'h0, 1'h0, 1'h1);
      define(4'hB, 8'h02);
      update(8'hF8, 7, -1);
      FP.quad(4, 1'h1);
      tick(10);
      chk_val(count_read_path, 32'h0000_0007);
      FP.set_lines(1'h0, 1'h1, 1'h1);
      chk_val(count_read_path, 32'h0000_0007);
      FP.set_lines(1'h0, 1'h1, 1'h0);
      chk_val(count_read_path, 32'h0000_0000);
      FP.set_lines(1'h0, 1'h0, 1'h0);
      FP.quad(4, 1'h1);
      tick(10);
      chk_val(count_read_path, 32'h0000_0004);
      report_and_stop();
   end
endmodule // high_speed_event_counter_tb

bind high_speed_event_counter hsec_props #(.COUNT_W(COUNT_W)) PROPS (.*);

`default_nettype wire

// >>> hsc_pkg.sv
// shared constants, types and mode decoding for the high-speed event counter
package hsc_pkg;

   // width of the running count and the preset target
   localparam int unsigned COUNT_W = 32;
   // width of the mode number given with the definition command
   localparam int unsigned MODE_W = 4;
   localparam logic [3:0] MODE_LAST = 4'hB;

   // counter control byte field positions
   localparam int unsigned CTRL_RST_POL_BIT   = 0;
   localparam int unsigned CTRL_START_POL_BIT = 1;
   localparam int unsigned CTRL_RATE_BIT      = 2;
   localparam int unsigned CTRL_DIR_BIT       = 3;
   localparam int unsigned CTRL_DIR_WR_BIT    = 4;
   localparam int unsigned CTRL_PRESET_WR_BIT = 5;
   localparam int unsigned CTRL_COUNT_WR_BIT  = 6;
   localparam int unsigned CTRL_ENABLE_BIT    = 7;

   // reset values: active-high reset and start, fourfold quadrature rate
   localparam logic RST_POL_RESET   = 1'b0;
   localparam logic START_POL_RESET = 1'b0;
   localparam logic RATE_1X_RESET   = 1'b0;
   localparam logic DIR_RESET       = 1'b1;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
   localparam logic [31:0] PRESET_RESET = 32'h0000_0000;

   // coincidence window of the two-clock modes
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned COINC_NS      = 300;
   // longest time, so it rounds down
   localparam int unsigned COINC_CYCLES  = COINC_NS / CLK_PERIOD_NS;
   localparam int unsigned COINC_W       = 5;

   // the four counter families
   typedef enum logic [1:0] {
      FAM_INT_DIR = 2'h0,
      FAM_EXT_DIR = 2'h1,
      FAM_TWO_CLK = 2'h2,
      FAM_QUAD    = 2'h3
   } family_t;

   // two-clock pending-edge states; each pending state is one bit from idle
   typedef enum logic [1:0] {
      CO_IDLE = 2'h0,
      CO_UP   = 2'h1,
      CO_DOWN = 2'h2
   } coinc_t;

   // family of a mode number, three modes each
   function automatic family_t mode_family(input logic [3:0] mode);
      if (mode < 4'h3) begin
         return FAM_INT_DIR;
      end else if (mode < 4'h6) begin
         return FAM_EXT_DIR;
      end else if (mode < 4'h9) begin
         return FAM_TWO_CLK;
      end else begin
         return FAM_QUAD;
      end
   endfunction

   // position of a mode inside its family: 0 bare, 1 reset, 2 reset+start
   function automatic logic [1:0] mode_variant(input logic [3:0] mode);
      logic [3:0] r;
      r = mode % 4'h3;
      return r[1:0];
   endfunction

   function automatic logic mode_has_reset(input logic [3:0] mode);
      return mode_variant(mode) != 2'h0;
   endfunction

   function automatic logic mode_has_start(input logic [3:0] mode);
      return mode_variant(mode) == 2'h2;
   endfunction

endpackage

// >>> hsec_props.sv
// port-level assertions for the high-speed event counter
`timescale 1ns/10ps
`default_nettype none

module hsec_props #(
   parameter int unsigned COUNT_W = 32
) (
   input wire logic               clk,
   input wire logic               srst,
   input wire logic               controller_stopped,
   input wire logic               counter_definition_command,
   input wire logic [3:0]         definition_mode,
   input wire logic               counter_update_command,
   input wire logic [7:0]         counter_control_byte,
   input wire logic [COUNT_W-1:0] staged_current_value,
   input wire logic [COUNT_W-1:0] count_read_path,
   input wire logic               counter_defined,
   input wire logic               counter_enabled,
   input wire logic               count_direction_up,
   input wire logic               count_equals_preset,
   input wire logic               equal_event,
   input wire logic               reset_event
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic upd_ok;

   // an update the counter must accept
   assign upd_ok = counter_update_command && counter_defined &&
                   !controller_stopped;

   def_take_a: assert property (
      counter_definition_command && !counter_defined &&
      !controller_stopped && definition_mode <= 4'hB |=> counter_defined)
      else $error("definition not taken");
   // an active reset pin may override the load, so zero is accepted too
   count_load_a: assert property (
      upd_ok && counter_control_byte[6] |=>
      count_read_path == $past(staged_current_value) || count_read_path == '0)
      else $error("staged count not loaded");
   enable_upd_a: assert property (
      upd_ok |=> counter_enabled == $past(counter_control_byte[7]))
      else $error("enable not taken from update");
   dir_upd_a: assert property (
      upd_ok && counter_control_byte[4] |=>
      count_direction_up == $past(counter_control_byte[3]))
      else $error("direction not taken from update");
   refused_upd_a: assert property (
      counter_update_command && !counter_defined |=>
      $stable(count_read_path) && !counter_enabled)
      else $error("update before definition took effect");
   stop_clear_a: assert property (
      controller_stopped |=> !counter_defined && !counter_enabled)
      else $error("stop did not clear definition");
   eq_cause_a: assert property (
      equal_event |-> count_read_path != $past(count_read_path))
      else $error("equal event without count change");
   count_hold_a: assert property (
      !counter_enabled && !counter_update_command |=>
      $stable(count_read_path))
      else $error("disabled counter moved");
   eq_level_a: assert property (
      equal_event |-> count_equals_preset)
      else $error("equal event without equality");
   rst_zero_a: assert property (
      reset_event |-> count_read_path == '0)
      else $error("reset event with nonzero count");
endmodule // hsec_props

`default_nettype wire

// >>> pin_sync_edge.sv
// two-flop synchronisers with edge detection for the counter input pins
`timescale 1ns/10ps
`default_nettype none

module pin_sync_edge #(
   parameter int unsigned WIDTH = 4
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] prev_reg;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("pin_sync_edge needs at least one pin");
      end
   endgenerate

   // first stage feeds only the second; edges compare stage two and three
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edges per bit, one cycle long
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_edge
         assign level[i] = sync_reg[i];
         assign rise[i]  = sync_reg[i] & ~prev_reg[i];
         assign fall[i]  = ~sync_reg[i] & prev_reg[i];
      end
   endgenerate

endmodule // pin_sync_edge

`default_nettype wire
